// File: rtl/ext_mgmt_pkg.sv
// constants, types and register map of the extended-register management block
// assumes the standard two-wire serial management frame, sampled in the system clock domain
package ext_mgmt_pkg;

  // ----------------------------------------------------------------
  // register map (5-bit management addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0]  REG_ACCESS_CTRL       = 5'h0d;
  localparam logic [4:0]  REG_WINDOW            = 5'h0e;
  localparam logic [4:0]  REG_STATUS            = 5'h10;
  localparam logic [4:0]  REG_FALSE_CARRIER_CNT = 5'h14;
  localparam logic [4:0]  REG_RX_ERR_CNT        = 5'h15;
  localparam logic [4:0]  REG_TEN_MEG_STATUS    = 5'h1a;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          FUNC_MSB       = 15;
  localparam int          FUNC_LSB       = 14;
  localparam int          DEVSEL_MSB     = 4;
  localparam int          DEVSEL_LSB     = 0;
  localparam logic [4:0]  OWN_DEVICE     = 5'h1f;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  localparam logic [15:0] EXT_BASE       = 16'h0010;
  localparam int          ST_CROSSOVER   = 14;
  localparam int          ST_RX_ERROR    = 13;
  localparam int          ST_POLARITY    = 12;
  localparam int          ST_FALSE_CARR  = 11;

  // ----------------------------------------------------------------
  // serial frame constants
  // ----------------------------------------------------------------
  localparam logic [5:0]  PREAMBLE_LEN   = 6'h20;
  localparam logic [5:0]  HDR_LAST       = 6'h0d;
  localparam logic [5:0]  DATA_LAST      = 6'h0f;
  localparam logic [1:0]  FRAME_START    = 2'h1;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;

  typedef enum logic [1:0] {
    FN_ADDR        = 2'b00,
    FN_DATA        = 2'b01,
    FN_DATA_INC_RW = 2'b10,
    FN_DATA_INC_WR = 2'b11
  } window_func_e;

  typedef enum logic [1:0] {
    FR_PREAMBLE = 2'b00,
    FR_HEADER   = 2'b01,
    FR_TURN     = 2'b10,
    FR_DATA     = 2'b11
  } frame_e;

  typedef struct packed {
    logic [1:0] start;
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regad;
  } mgmt_hdr_s;

endpackage

// File: rtl/ext_reg_mem.sv
// small storage for the extended register set, registered read data
// assumes a single clock; write and read may hit the same word in one cycle
`timescale 1ns/1ps
module ext_reg_mem #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // write port
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  // read port
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o
);

  logic [DATA_W-1:0] mem_q [2**ADDR_W];

  // ----------------------------------------------------------------
  // storage, no reset so it maps to plain ram
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // read data from a flop; old word on a same-cycle collision
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule

// File: rtl/ext_mgmt_regs.sv
// serial management slave with indirect extended-register window and summary status
// assumes mdc/mdio already synchronous to clk_sys_i and mdc far slower than it
`timescale 1ns/1ps
module ext_mgmt_regs #(
  parameter logic [4:0] PHY_ADDR   = 5'h01,
  parameter int         EXT_ADDR_W = 4
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // serial management pins
  input  wire logic mdc_i,
  input  wire logic mdio_i,
  output logic      mdio_o,
  output logic      mdio_oe_o,
  // crossover control and state
  input  wire logic an_mdix_swapped_i,
  input  wire logic auto_crossover_enable_i,
  input  wire logic crossover_force_i,
  // line events
  input  wire logic rx_error_event_i,
  input  wire logic false_carrier_event_i,
  input  wire logic polarity_inverted_i
);

  // ----------------------------------------------------------------
  // frame engine state
  // ----------------------------------------------------------------
  ext_mgmt_pkg::frame_e    state_q;
  ext_mgmt_pkg::mgmt_hdr_s hdr_q;
  logic [5:0]              cnt_q;
  logic [15:0]             shift_q;
  logic                    is_read_q;
  logic                    mdc_q;
  logic                    mdio_q;
  logic                    mdio_oe_q;

  // register state
  ext_mgmt_pkg::window_func_e func_q;
  logic [4:0]                 dev_q;
  logic [15:0]                ptr_q;
  logic                       xover_q;
  logic                       rx_err_q;
  logic                       pol_q;
  logic                       fc_q;
  logic [15:0]                mem_rd;

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  wire                        mdc_rise  = mdc_i & ~mdc_q;
  wire ext_mgmt_pkg::mgmt_hdr_s hdr_w   = ext_mgmt_pkg::mgmt_hdr_s'({shift_q[12:0], mdio_i});
  wire                        hdr_ok    = (hdr_w.start == ext_mgmt_pkg::FRAME_START) && (hdr_w.phy == PHY_ADDR)
                                          && (hdr_w.op == ext_mgmt_pkg::OP_READ || hdr_w.op == ext_mgmt_pkg::OP_WRITE);
  wire                        last_bit  = mdc_rise && state_q == ext_mgmt_pkg::FR_DATA
                                          && cnt_q == ext_mgmt_pkg::DATA_LAST;
  wire                        write_done = last_bit && !is_read_q;
  wire                        read_done  = last_bit && is_read_q;
  wire                        read_capture = mdc_rise && state_q == ext_mgmt_pkg::FR_TURN
                                             && cnt_q == 6'h00 && is_read_q;
  wire [15:0]                 wdata     = {shift_q[14:0], mdio_i};

  // window steering; foreign device select makes the window inert
  wire dev_ok    = dev_q == ext_mgmt_pkg::OWN_DEVICE;
  wire win_sel   = hdr_q.regad == ext_mgmt_pkg::REG_WINDOW;
  wire win_wr    = write_done && win_sel && dev_ok;
  wire win_rd    = read_done && win_sel && dev_ok;
  wire data_func = func_q != ext_mgmt_pkg::FN_ADDR;
  wire ptr_load  = win_wr && !data_func;
  wire ptr_inc   = (win_wr && (func_q == ext_mgmt_pkg::FN_DATA_INC_RW || func_q == ext_mgmt_pkg::FN_DATA_INC_WR))
                   || (win_rd && func_q == ext_mgmt_pkg::FN_DATA_INC_RW);

  // extended set starts at pointer 0x0010, inside the 5-bit directly addressed range
  wire [15:0] ext_off  = ptr_q - ext_mgmt_pkg::EXT_BASE;
  wire        in_range = (ptr_q >= ext_mgmt_pkg::EXT_BASE) && (ext_off[15:EXT_ADDR_W] == '0);
  wire        mem_we   = win_wr && data_func && in_range;

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  wire [15:0] ctrl_rd   = {func_q, 9'h000, dev_q};
  wire [15:0] status_rd = {1'b0, xover_q, rx_err_q, pol_q, fc_q, 11'h000};
  wire [15:0] win_rd_v  = !dev_ok ? 16'h0000 : !data_func ? ptr_q : in_range ? mem_rd : 16'h0000;
  wire [15:0] rd_mux    = (hdr_q.regad == ext_mgmt_pkg::REG_ACCESS_CTRL) ? ctrl_rd
                        : (hdr_q.regad == ext_mgmt_pkg::REG_WINDOW)      ? win_rd_v
                        : (hdr_q.regad == ext_mgmt_pkg::REG_STATUS)      ? status_rd : 16'h0000;

  // clear-on-read strobes act when the read value is snapshotted
  wire clr_rx  = read_capture && hdr_q.regad == ext_mgmt_pkg::REG_RX_ERR_CNT;
  wire clr_fc  = read_capture && hdr_q.regad == ext_mgmt_pkg::REG_FALSE_CARRIER_CNT;
  wire clr_pol = read_capture && hdr_q.regad == ext_mgmt_pkg::REG_TEN_MEG_STATUS;

  // force wins, then the algorithm, else normal pairs
  wire xover_d = crossover_force_i ? 1'b1 : (auto_crossover_enable_i ? an_mdix_swapped_i : 1'b0);

  // ----------------------------------------------------------------
  // frame engine: sample on mdc rise, drive read bits after it
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q   <= ext_mgmt_pkg::FR_PREAMBLE;
      hdr_q     <= '0;
      cnt_q     <= 6'h00;
      shift_q   <= 16'h0000;
      is_read_q <= 1'b0;
      mdc_q     <= 1'b0;
      mdio_q    <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      mdc_q <= mdc_i;
      if (mdc_rise) begin
        unique case (state_q)
          ext_mgmt_pkg::FR_PREAMBLE: begin
            if (mdio_i) begin
              cnt_q <= (cnt_q == ext_mgmt_pkg::PREAMBLE_LEN) ? cnt_q : cnt_q + 6'h01;
            end else if (cnt_q == ext_mgmt_pkg::PREAMBLE_LEN) begin
              state_q <= ext_mgmt_pkg::FR_HEADER; // zero just seen is first start bit
              cnt_q   <= 6'h01;
              shift_q <= 16'h0000;
            end else begin
              cnt_q <= 6'h00;
            end
          end
          ext_mgmt_pkg::FR_HEADER: begin
            shift_q <= wdata;
            if (cnt_q == ext_mgmt_pkg::HDR_LAST) begin
              cnt_q     <= 6'h00;
              hdr_q     <= hdr_w;
              is_read_q <= hdr_w.op == ext_mgmt_pkg::OP_READ;
              state_q   <= hdr_ok ? ext_mgmt_pkg::FR_TURN : ext_mgmt_pkg::FR_PREAMBLE;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          ext_mgmt_pkg::FR_TURN: begin
            if (cnt_q == 6'h00) begin
              cnt_q <= 6'h01;
              if (is_read_q) begin
                mdio_oe_q <= 1'b1; // second turnaround bit driven low
                mdio_q    <= 1'b0;
                shift_q   <= rd_mux;
              end
            end else begin
              cnt_q   <= 6'h00;
              state_q <= ext_mgmt_pkg::FR_DATA;
              if (is_read_q) begin
                mdio_q  <= shift_q[15];
                shift_q <= {shift_q[14:0], 1'b0};
              end
            end
          end
          ext_mgmt_pkg::FR_DATA: begin
            shift_q <= wdata;
            if (is_read_q) begin
              mdio_q <= shift_q[15];
            end
            if (cnt_q == ext_mgmt_pkg::DATA_LAST) begin
              state_q   <= ext_mgmt_pkg::FR_PREAMBLE;
              cnt_q     <= 6'h00;
              mdio_oe_q <= 1'b0;
              mdio_q    <= 1'b0;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // access control and pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      func_q <= ext_mgmt_pkg::FN_ADDR;
      dev_q  <= ext_mgmt_pkg::CTRL_RESET[ext_mgmt_pkg::DEVSEL_MSB:ext_mgmt_pkg::DEVSEL_LSB];
      ptr_q  <= ext_mgmt_pkg::PTR_RESET;
    end else begin
      if (write_done && hdr_q.regad == ext_mgmt_pkg::REG_ACCESS_CTRL) begin
        func_q <= ext_mgmt_pkg::window_func_e'(wdata[ext_mgmt_pkg::FUNC_MSB:ext_mgmt_pkg::FUNC_LSB]);
        dev_q  <= wdata[ext_mgmt_pkg::DEVSEL_MSB:ext_mgmt_pkg::DEVSEL_LSB]; // reserved bits dropped
      end
      if (ptr_load) begin
        ptr_q <= wdata;
      end else if (ptr_inc) begin
        ptr_q <= ptr_q + 16'h0001;
      end
    end
  end

  // status latches: a same-cycle event beats the clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      xover_q  <= 1'b0;
      rx_err_q <= 1'b0;
      pol_q    <= 1'b0;
      fc_q     <= 1'b0;
    end else begin
      xover_q  <= xover_d;
      rx_err_q <= rx_error_event_i | (rx_err_q & ~clr_rx);
      pol_q    <= polarity_inverted_i | (pol_q & ~clr_pol);
      fc_q     <= false_carrier_event_i | (fc_q & ~clr_fc);
    end
  end

  ext_reg_mem #(
    .DATA_W (16),
    .ADDR_W (EXT_ADDR_W)
  ) u_ext_mem (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .wr_en_i   (mem_we),
    .wr_addr_i (ext_off[EXT_ADDR_W-1:0]),
    .wr_data_i (wdata),
    .rd_addr_i (ext_off[EXT_ADDR_W-1:0]),
    .rd_data_o (mem_rd)
  );

  assign mdio_o    = mdio_q;
  assign mdio_oe_o = mdio_oe_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_status_reserved: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    read_capture && hdr_q.regad == ext_mgmt_pkg::REG_STATUS |=> shift_q[15] == 1'b0)
    else $error("status bit 15 not zero");
  a_ptr_hold_nopost: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (write_done || read_done) && win_sel && func_q == ext_mgmt_pkg::FN_DATA |=> $stable(ptr_q))
    else $error("pointer moved without post increment");
  a_ptr_inc_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    read_done && win_sel && dev_ok && func_q == ext_mgmt_pkg::FN_DATA_INC_RW
    |=> ptr_q == $past(ptr_q) + 16'h0001)
    else $error("pointer not incremented after read");
  a_ptr_read_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    read_done && win_sel && func_q == ext_mgmt_pkg::FN_DATA_INC_WR |=> $stable(ptr_q))
    else $error("pointer moved after read in write-only increment");
  a_foreign_dev_ignored: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (write_done || read_done) && win_sel && !dev_ok |=> $stable(ptr_q))
    else $error("foreign device select changed pointer");
  a_xover_forced: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    crossover_force_i |=> xover_q)
    else $error("forced crossover not reported");
  a_rx_err_latch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rx_error_event_i ##1 !clr_rx[*3] |=> rx_err_q)
    else $error("receive error latch lost");
  a_pol_status_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pol_q && read_capture && hdr_q.regad == ext_mgmt_pkg::REG_STATUS |=> pol_q)
    else $error("polarity cleared by summary read");
  a_fc_clear_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clr_fc && !false_carrier_event_i |=> !fc_q)
    else $error("false carrier latch not cleared");

endmodule

// File: verification/mgmt_master.sv
// station management controller model: sends serial management frames
// assumes the device samples mdc rises in clk_sys_i and mdio carries a pull-up
`timescale 1ns/1ps
module mgmt_master #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // clock
  input  wire logic clk_sys_i,
  // serial management pins
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o,
  input  wire logic mdio_i
);
  logic rbit;

  // idle: mdc low, line released to the pull-up; nonblocking like the tasks
  initial begin
    mdc_o <= 1'b0;
    mdio_o <= 1'b1;
    mdio_oe_o <= 1'b0;
    rbit = 1'b0;
  end

  // ----------------------------------------------------------------
  // bit and frame tasks
  // ----------------------------------------------------------------
  // six system clocks per mdc period, so high and low both exceed two clocks
  task automatic bit_cycle(input logic b, input logic drv);
    @(posedge clk_sys_i);
    mdc_o <= 1'b0;
    mdio_o <= b;
    mdio_oe_o <= drv;
    repeat (3) @(posedge clk_sys_i);
    mdc_o <= 1'b1;
    rbit = mdio_i;
    repeat (2) @(posedge clk_sys_i);
  endtask

  // each frame has a fresh preamble, since a refused frame needs one again
  task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rdat);
    logic [13:0] hdr;
    hdr = {2'b01, (rd ? 2'b10 : 2'b01), PHY_ADDR, ra};
    rdat = 16'h0000;
    for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) bit_cycle(hdr[i], 1'b1);
    bit_cycle(1'b1, !rd);
    bit_cycle(1'b0, !rd);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(wd[i], !rd);
      rdat[i] = rbit;
    end
    @(posedge clk_sys_i);
    mdc_o <= 1'b0;
    mdio_oe_o <= 1'b0;
  endtask
endmodule

// File: verification/ext_reg_indirect_access_status_test.sv
// self-checking bench for the management register block
// assumes the controller model in mgmt_master and a pulled-up shared mdio line
`timescale 1ns/1ps
module ext_reg_indirect_access_status_test;
  logic        clk_sys_i;
  logic        rst_i;
  logic        mdc;
  logic        m_mdio;
  logic        m_oe;
  logic        d_mdio;
  logic        d_oe;
  logic        line;
  logic        swapped;
  logic        xen;
  logic        xforce;
  logic        rx_err;
  logic        fc_ev;
  logic        pol_inv;
  logic [15:0] rv;
  int          n_errors;
  int          checked;

  // wire level: device wins while enabled, pull-up when nobody drives
  assign line = d_oe ? d_mdio : (m_oe ? m_mdio : 1'b1);

  ext_mgmt_regs #(.PHY_ADDR(5'h01), .EXT_ADDR_W(4)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(line), .mdio_o(d_mdio), .mdio_oe_o(d_oe),
    .an_mdix_swapped_i(swapped), .auto_crossover_enable_i(xen), .crossover_force_i(xforce),
    .rx_error_event_i(rx_err), .false_carrier_event_i(fc_ev), .polarity_inverted_i(pol_inv));

  mgmt_master #(.PHY_ADDR(5'h01)) u_master (
    .clk_sys_i(clk_sys_i), .mdc_o(mdc), .mdio_o(m_mdio), .mdio_oe_o(m_oe), .mdio_i(line));

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    u_master.frame(1'b0, ra, wd, rv);
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] exp, input string what);
    u_master.frame(1'b1, ra, 16'h0000, rv);
    check(what, rv, exp);
  endtask

  task automatic ctrl(input logic [15:0] v);
    wr(ext_mgmt_pkg::REG_ACCESS_CTRL, v);
  endtask

  task automatic win_wr(input logic [15:0] v);
    wr(ext_mgmt_pkg::REG_WINDOW, v);
  endtask

  task automatic win_rd(input logic [15:0] exp, input string what);
    rd(ext_mgmt_pkg::REG_WINDOW, exp, what);
  endtask

  task automatic st(input logic [15:0] exp);
    rd(ext_mgmt_pkg::REG_STATUS, exp, "status");
  endtask

  // line inputs change at a rising edge; event inputs are one-clock pulses
  task automatic line_in(input logic f, input logic e, input logic s, input logic r, input logic c, input logic p);
    @(posedge clk_sys_i);
    xforce <= f;
    xen <= e;
    swapped <= s;
    rx_err <= r;
    fc_ev <= c;
    pol_inv <= p;
    @(posedge clk_sys_i);
    rx_err <= 1'b0;
    fc_ev <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // frames have fixed length, so only a stuck run reaches this bound
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    n_errors++;
    report_and_stop();
  end

  initial begin
    n_errors = 0;
    checked = 0;
    rst_i <= 1'b1;
    {swapped, xen, xforce, rx_err, fc_ev, pol_inv} <= 6'h00;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rd(ext_mgmt_pkg::REG_ACCESS_CTRL, 16'h0000, "ctrl reset");
    st(16'h0000);
    ctrl(16'hffff);
    rd(ext_mgmt_pkg::REG_ACCESS_CTRL, 16'hc01f, "ctrl reserved");
    ctrl(16'h0000);
    win_wr(16'h1234);
    ctrl(16'h001f);
    win_rd(16'h0000, "pointer after foreign");
    win_wr(16'h0010);
    win_rd(16'h0010, "pointer");
    ctrl(16'h401f);
    win_wr(16'ha5a5);
    win_rd(16'ha5a5, "data no increment");
    ctrl(16'h001f);
    win_rd(16'h0010, "pointer fn01");
    ctrl(16'h801f);
    win_wr(16'h1111);
    win_wr(16'h2222);
    ctrl(16'h001f);
    win_rd(16'h0012, "pointer after writes");
    win_wr(16'h0010);
    ctrl(16'h801f);
    win_rd(16'h1111, "ext word 0");
    win_rd(16'h2222, "ext word 1");
    ctrl(16'h001f);
    win_rd(16'h0012, "pointer after reads");
    win_wr(16'h0010);
    ctrl(16'hc01f);
    win_rd(16'h1111, "fn11 read a");
    win_rd(16'h1111, "fn11 read b");
    win_wr(16'h3333);
    ctrl(16'h001f);
    win_rd(16'h0011, "pointer fn11");
    win_wr(16'hffff);
    ctrl(16'h801f);
    win_rd(16'h0000, "out of range read");
    ctrl(16'h001f);
    win_rd(16'h0000, "pointer wrap");
    // data mode under a foreign device select: read gives zero, write and increment dropped
    win_wr(16'h0010);
    ctrl(16'h8000);
    win_rd(16'h0000, "foreign data read");
    win_wr(16'h5555);
    ctrl(16'h801f);
    win_rd(16'h3333, "word after foreign");
    wr(5'h03, 16'hffff);
    rd(5'h03, 16'h0000, "unmapped");
    wr(ext_mgmt_pkg::REG_STATUS, 16'hffff);
    st(16'h0000);
    line_in(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    st(16'h4000);
    line_in(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    st(16'h4000);
    line_in(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    st(16'h0000);
    line_in(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    st(16'h2000);
    line_in(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    st(16'h2000);
    rd(ext_mgmt_pkg::REG_RX_ERR_CNT, 16'h0000, "rx error counter");
    st(16'h0000);
    line_in(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    line_in(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    st(16'h1800);
    st(16'h1800);
    rd(ext_mgmt_pkg::REG_TEN_MEG_STATUS, 16'h0000, "ten meg status");
    st(16'h0800);
    rd(ext_mgmt_pkg::REG_FALSE_CARRIER_CNT, 16'h0000, "false carrier counter");
    st(16'h0000);
    report_and_stop();
  end
endmodule
